// ==== ppc_consts.vh ====
// Constants for the peripheral port cycle controller
`ifndef PPC_CONSTS_VH
`define PPC_CONSTS_VH

// Timing control register index and reset value
`define PPC_TIMING_INDEX 8'h19
`define PPC_TIMING_RESET 8'h00

// Timing control register fields
`define PPC_BIT_WIDTH 0
`define PPC_BIT_TERM 1
`define PPC_BIT_ADDR2SEL 2
`define PPC_BIT_CMD2RDY 3
`define PPC_BIT_SEL2CMD 4
`define PPC_BIT_STROBE 5
`define PPC_BIT_BUSY 7
`define PPC_WRITABLE_MASK 8'h3f

// Interval lengths in clocks
`define PPC_DLY_SHORT 3'h1
`define PPC_DLY_LONG 3'h2
`define PPC_STRB_SHORT 3'h2
`define PPC_STRB_LONG 3'h4
// Shortest read strobe that lets the synchronised data catch up with the pins
`define PPC_READ_SETTLE 3'h3

// Request buffer depth
`define PPC_FIFO_DEPTH 32

`endif

// ==== ppc_sync.v ====
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ppc_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Data
    input wire [WIDTH-1:0] asyncIn,
    output reg [WIDTH-1:0] syncOut
);

reg [WIDTH-1:0] meta_r;

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        meta_r <= {WIDTH{1'b0}};
        syncOut <= {WIDTH{1'b0}};
    end
    else
    begin
        meta_r <= asyncIn;
        syncOut <= meta_r;
    end
end

endmodule // ppc_sync

// ==== ppc_fifo.v ====
// Request FIFO with registered head word
`timescale 1ns/1ps
module ppc_fifo #(
    parameter WIDTH = 25,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Fill side
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    // Drain side
    output reg outValid,
    input wire outReady,
    output reg [WIDTH-1:0] outData
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wrPtr_r;
reg [AW-1:0] rdPtr_r;
reg [AW:0] count_r;

wire memFull = (count_r == DEPTH[AW:0]);
wire memEmpty = (count_r == {(AW+1){1'b0}});
wire push = inValid && !memFull;
// The head register refills whenever it is free or being drained
wire pop = !memEmpty && (!outValid || outReady);

assign inReady = !memFull;

function [AW-1:0] ptrInc;
    input [AW-1:0] p;
    begin
        ptrInc = (p == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : p + 1'b1;
    end
endfunction

always @(posedge clk)
begin
    if (push)
        mem[wrPtr_r] <= inData;
end

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        wrPtr_r <= {AW{1'b0}};
        rdPtr_r <= {AW{1'b0}};
        count_r <= {(AW+1){1'b0}};
        outValid <= 1'b0;
        outData <= {WIDTH{1'b0}};
    end
    else
    begin
        if (push)
            wrPtr_r <= ptrInc(wrPtr_r);
        if (pop)
        begin
            rdPtr_r <= ptrInc(rdPtr_r);
            outData <= mem[rdPtr_r];
            outValid <= 1'b1;
        end
        else if (outReady)
            outValid <= 1'b0;
        if (push && !pop)
            count_r <= count_r + 1'b1;
        else if (pop && !push)
            count_r <= count_r - 1'b1;
    end
end

endmodule // ppc_fifo

// ==== ppc_cycle_ctrl.v ====
// Peripheral port cycle controller: host requests to strobe cycles
//
// Summary of operation
// [R1] Width bit selects 8- or 16-bit port
// [R2] Ready seen at sample: minimum strobe sizes; a short read strobe runs three clocks, not two
// [R3] Ready absent at sample: wait for ready
// [R4] Write data driven before write strobe
// [R5] Ready mode: read data at strobe end
// [R6] Ready mode: target-ready next clock after ready
// [R7] Acknowledge mode: read data at acknowledge
// [R8] Acknowledge mode: target-ready next clock after acknowledge
// [R9] Zero: 8-bit, ready mode, minimum timings
// [R10] Bits 5..2 choose interval lengths
// [R11] Bit 1 selects ready or acknowledge ending
// [R12] 8-bit word splits into two byte cycles
// [R13] Address pins follow 128- or 16-byte configuration
// [R14] Address, select, strobe; release strobe then select
`timescale 1ns/1ps
`include "ppc_consts.vh"
module ppc_cycle_ctrl #(
    parameter FIFO_DEPTH = `PPC_FIFO_DEPTH
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Host request stream
    input wire hostValid,
    output wire hostReady,
    input wire hostWrite,
    input wire hostWord,
    input wire [6:0] hostAddr,
    input wire [15:0] hostWdata,
    // Host completion
    output reg hostTrdy_n,
    output reg hostError,
    output reg [15:0] hostRdata,
    // Graphics register group access
    input wire regWrite,
    input wire [7:0] regIndex,
    input wire [7:0] regWdata,
    output reg [7:0] regRdata,
    // Configuration strap: 1 for 128-byte space, 0 for 16-byte space
    input wire cfg128Strap,
    // Peripheral port pins
    output reg [6:0] peripheralAddressOut,
    output reg peripheralSelect_n,
    output reg peripheralReadStrobe_n,
    output reg peripheralWriteStrobe_n,
    input wire peripheralReadyIn,
    input wire [15:0] peripheralDataBusIn,
    output reg [15:0] peripheralDataBusOut,
    output reg peripheralDataBusOe_n
);

localparam FW = 25;
localparam S_IDLE = 3'h0;
localparam S_ADDR = 3'h1;
localparam S_SEL = 3'h2;
localparam S_CMD = 3'h3;
localparam S_END = 3'h4;
localparam S_DESEL = 3'h5;

reg [7:0] peripheral_cycle_timing;
reg [2:0] state_r;
reg [2:0] cnt_r;
reg isWrite_r;
reg isWord_r;
reg secondByte_r;
reg [1:0] lane_r;
reg [4:0] addr_r;
reg [15:0] wdata_r;
reg [7:0] lowByte_r;
reg ackPrev_r;
reg lastByte_r;

wire fifoValid;
wire fifoReady;
wire [FW-1:0] fifoData;
wire readySync;
wire cfg128Sync;
wire [15:0] dataSync;

// Pin shared between ready and active-low acknowledge
wire dataAcknowledge_n = readySync;

ppc_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH),
    .AW(5)
) reqFifo (
    .clk(clk),
    .rst_n(rst_n),
    .inValid(hostValid),
    .inReady(hostReady),
    .inData({hostWrite, hostWord, hostAddr[1:0], hostAddr[6:2], hostWdata}),
    .outValid(fifoValid),
    .outReady(fifoReady),
    .outData(fifoData)
);

ppc_sync #(
    .WIDTH(18)
) pinSync (
    .clk(clk),
    .rst_n(rst_n),
    .asyncIn({peripheralReadyIn, cfg128Strap, peripheralDataBusIn}),
    .syncOut({readySync, cfg128Sync, dataSync})
);

function [2:0] dly;
    input sel;
    begin
        dly = sel ? `PPC_DLY_LONG : `PPC_DLY_SHORT;
    end
endfunction

wire busWide = peripheral_cycle_timing[`PPC_BIT_WIDTH]; // see [R1]
wire ackMode = peripheral_cycle_timing[`PPC_BIT_TERM]; // see [R11]
wire [2:0] tAddrSel = dly(peripheral_cycle_timing[`PPC_BIT_ADDR2SEL]); // see [R10]
wire [2:0] tSelCmd = dly(peripheral_cycle_timing[`PPC_BIT_SEL2CMD]); // see [R10]
wire [2:0] tCmdRdy = dly(peripheral_cycle_timing[`PPC_BIT_CMD2RDY]); // see [R10]
wire [2:0] tStrobe = peripheral_cycle_timing[`PPC_BIT_STROBE] ?
    `PPC_STRB_LONG : `PPC_STRB_SHORT; // see [R10]
wire busy = (state_r != S_IDLE) || fifoValid;

// Ready counts only once the command-to-ready interval has run out
wire readyOk = (cnt_r >= tCmdRdy) && readySync; // see [R3]
wire ackLead = ackPrev_r && !dataAcknowledge_n;
// Synced data lags the pins by two clocks, so a read strobe runs at least three
// clocks; a shorter one would capture a value sampled before the strobe fell
wire dataSettled = isWrite_r || (cnt_r >= `PPC_READ_SETTLE); // see [R5]
wire readyDone = readyOk && (cnt_r >= tStrobe) && dataSettled; // see [R2]
wire cycleDone = ackMode ? ackLead : readyDone;

assign fifoReady = (state_r == S_IDLE);

// Register access
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        peripheral_cycle_timing <= `PPC_TIMING_RESET; // see [R9]
        regRdata <= 8'h00;
    end
    else
    begin
        if (regWrite && regIndex == `PPC_TIMING_INDEX)
            peripheral_cycle_timing <= regWdata & `PPC_WRITABLE_MASK; // see [R9]
        if (regIndex == `PPC_TIMING_INDEX)
        begin
            regRdata <= peripheral_cycle_timing;
            regRdata[`PPC_BIT_BUSY] <= busy;
        end
        else
            regRdata <= 8'h00;
    end
end

// Address for the current byte or word
function [6:0] pinAddr;
    input wide128;
    input [4:0] a;
    input [1:0] lane;
    begin
        if (wide128)
            pinAddr = {a, 2'b00}; // see [R13]
        else
            pinAddr = {3'b000, a[1:0], lane}; // see [R13]
    end
endfunction

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        state_r <= S_IDLE;
        cnt_r <= 3'h0;
        isWrite_r <= 1'b0;
        isWord_r <= 1'b0;
        secondByte_r <= 1'b0;
        lane_r <= 2'h0;
        addr_r <= 5'h00;
        wdata_r <= 16'h0000;
        lowByte_r <= 8'h00;
        ackPrev_r <= 1'b1;
        lastByte_r <= 1'b0;
        hostTrdy_n <= 1'b1;
        hostError <= 1'b0;
        hostRdata <= 16'h0000;
        peripheralAddressOut <= 7'h00;
        peripheralSelect_n <= 1'b1;
        peripheralReadStrobe_n <= 1'b1;
        peripheralWriteStrobe_n <= 1'b1;
        peripheralDataBusOut <= 16'h0000;
        peripheralDataBusOe_n <= 1'b1;
    end
    else
    begin
        ackPrev_r <= dataAcknowledge_n;
        hostTrdy_n <= 1'b1;
        hostError <= 1'b0;
        case (state_r)
            S_IDLE:
            begin
                if (fifoValid)
                begin
                    if (busWide && !fifoData[23])
                    begin
                        // Byte access on a 16-bit port is refused at once
                        hostTrdy_n <= 1'b0; // see [R12]
                        hostError <= 1'b1;
                    end
                    else
                    begin
                        isWrite_r <= fifoData[24];
                        isWord_r <= fifoData[23];
                        secondByte_r <= 1'b0;
                        lane_r <= fifoData[23] ? {fifoData[22], 1'b0} : fifoData[22:21];
                        addr_r <= fifoData[20:16];
                        wdata_r <= fifoData[15:0];
                        lastByte_r <= busWide || !fifoData[23]; // see [R12]
                        peripheralAddressOut <= pinAddr(cfg128Sync, fifoData[20:16],
                            fifoData[23] ? {fifoData[22], 1'b0} : fifoData[22:21]);
                        // Data goes out with the address, well ahead of the strobe
                        peripheralDataBusOut <= busWide ? fifoData[15:0] :
                            {8'h00, fifoData[7:0]}; // see [R4]
                        peripheralDataBusOe_n <= !fifoData[24]; // see [R4]
                        cnt_r <= 3'h1;
                        state_r <= S_ADDR;
                    end
                end
            end
            S_ADDR:
            begin
                if (cnt_r >= tAddrSel)
                begin
                    peripheralSelect_n <= 1'b0; // see [R14]
                    cnt_r <= 3'h1;
                    state_r <= S_SEL;
                end
                else
                    cnt_r <= cnt_r + 3'h1;
            end
            S_SEL:
            begin
                if (cnt_r >= tSelCmd)
                begin
                    peripheralReadStrobe_n <= isWrite_r; // see [R14]
                    peripheralWriteStrobe_n <= !isWrite_r; // see [R4]
                    cnt_r <= 3'h1;
                    state_r <= S_CMD;
                end
                else
                    cnt_r <= cnt_r + 3'h1;
            end
            S_CMD:
            begin
                if (cnt_r != 3'h7)
                    cnt_r <= cnt_r + 3'h1;
                if (cycleDone)
                begin
                    peripheralReadStrobe_n <= 1'b1;
                    peripheralWriteStrobe_n <= 1'b1;
                    if (!isWrite_r)
                    begin
                        // Data captured at strobe release or acknowledge leading edge
                        if (busWide)
                            hostRdata <= dataSync; // see [R5] see [R7]
                        else if (secondByte_r)
                            hostRdata <= {dataSync[7:0], lowByte_r};
                        else if (lastByte_r)
                            hostRdata <= {8'h00, dataSync[7:0]};
                        else
                            lowByte_r <= dataSync[7:0];
                    end
                    if (lastByte_r)
                        hostTrdy_n <= 1'b0; // see [R6] see [R8]
                    state_r <= S_END;
                end
            end
            S_END:
            begin
                peripheralSelect_n <= 1'b1; // see [R14]
                state_r <= S_DESEL;
            end
            S_DESEL:
            begin
                if (!lastByte_r)
                begin
                    // Second byte of a word on the 8-bit port
                    secondByte_r <= 1'b1; // see [R12]
                    lastByte_r <= 1'b1;
                    lane_r <= lane_r + 2'h1;
                    peripheralAddressOut <= pinAddr(cfg128Sync, addr_r, lane_r + 2'h1);
                    peripheralDataBusOut <= {8'h00, wdata_r[15:8]}; // see [R4]
                    cnt_r <= 3'h1;
                    state_r <= S_ADDR;
                end
                else
                begin
                    peripheralDataBusOe_n <= 1'b1;
                    state_r <= S_IDLE;
                end
            end
            default:
                state_r <= S_IDLE;
        endcase
    end
end

endmodule // ppc_cycle_ctrl

// ==== ppc_cycle_props.sv ====
// Concurrent checks on the peripheral port cycle controller pins
`timescale 1ns/1ps
module ppc_cycle_props (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Host and register side
    input wire hostTrdy_n,
    input wire hostError,
    input wire regWrite,
    input wire [7:0] regIndex,
    input wire [7:0] regWdata,
    // Peripheral pins
    input wire peripheralSelect_n,
    input wire peripheralReadStrobe_n,
    input wire peripheralWriteStrobe_n,
    input wire [15:0] peripheralDataBusOut,
    input wire peripheralDataBusOe_n
);
    reg [5:0] timing_r;
    wire stbOff;
    assign stbOff = peripheralReadStrobe_n & peripheralWriteStrobe_n;
    // Shadow copy so interval checks know the programmed lengths
    always @(posedge clk or negedge rst_n)
        if (!rst_n)
            timing_r <= 6'h00;
        else if (regWrite && regIndex == 8'h19)
            timing_r <= regWdata[5:0];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wr_data_a: assert property ($fell(peripheralWriteStrobe_n) |->
        !peripheralDataBusOe_n && $past(peripheralDataBusOe_n) == 1'b0) else $error("write data late");
    sel_first_a: assert property ($fell(stbOff) |->
        $past(peripheralSelect_n) == 1'b0) else $error("strobe before select");
    sel_last_a: assert property ($rose(peripheralSelect_n) |->
        stbOff && $past(stbOff)) else $error("select released before strobe");
    one_strobe_a: assert property (stbOff || peripheralReadStrobe_n ||
        peripheralWriteStrobe_n) else $error("both strobes active");
    min_strobe_a: assert property ($fell(stbOff) && !timing_r[1] |->
        !stbOff [*2]) else $error("strobe shorter than two clocks");
    long_strobe_a: assert property ($fell(stbOff) && timing_r[5] && !timing_r[1] |->
        !stbOff [*4]) else $error("strobe shorter than four clocks");
    sel_cmd_a: assert property ($fell(stbOff) && timing_r[4] |->
        $past(peripheralSelect_n, 2) == 1'b0) else $error("select to command too short");
    trdy_after_a: assert property (!hostTrdy_n && !hostError |-> stbOff &&
        ($past(stbOff) == 1'b0 || $past(stbOff, 2) == 1'b0)) else $error("target ready misplaced");
    trdy_pulse_a: assert property (!hostTrdy_n |=> hostTrdy_n)
        else $error("target ready too long");
    err_trdy_a: assert property (hostError |-> !hostTrdy_n && stbOff &&
        peripheralSelect_n) else $error("refusal without target ready");
    narrow_bus_a: assert property (!peripheralDataBusOe_n && !timing_r[0] |->
        peripheralDataBusOut[15:8] == 8'h00) else $error("upper byte driven in 8-bit mode");
endmodule // ppc_cycle_props

// ==== ppc_periph_model.sv ====
// Behavioural peripheral on the far side of the port
`timescale 1ns/1ps
module ppc_periph_model (
    // Clock and test controls
    input wire clk,
    input wire ackMode,
    input wire [3:0] lat,
    input wire [15:0] val,
    // Pins from the controller
    input wire [6:0] peripheralAddressOut,
    input wire peripheralReadStrobe_n,
    input wire peripheralWriteStrobe_n,
    input wire [15:0] peripheralDataBusOut,
    // Pins to the controller
    output wire peripheralReadyIn,
    output wire [15:0] peripheralDataBusIn,
    output reg [15:0] wrSeen
);
    reg [4:0] cnt_r;
    reg rdy_r;
    wire [15:0] drv;
    // Peripheral stretches the cycle by lat clocks before answering
    always @(posedge clk)
    begin
        if (peripheralReadStrobe_n && peripheralWriteStrobe_n)
        begin
            cnt_r <= 5'h00;
            rdy_r <= 1'b0;
        end
        else if (cnt_r >= {1'b0, lat})
            rdy_r <= 1'b1;
        else
            cnt_r <= cnt_r + 5'h01;
        if (!peripheralWriteStrobe_n)
            wrSeen <= peripheralDataBusOut;
    end
    // With no latency ready stays up, so it is already true when sampled
    assign peripheralReadyIn = ackMode ? !rdy_r : (rdy_r || lat == 4'h0);
    assign drv = {val[15:8], val[7:0] ^ {1'b0, peripheralAddressOut}};
    // Released bus shows the inverse so stale data cannot pass
    assign peripheralDataBusIn = peripheralReadStrobe_n ? ~drv : drv;
endmodule // ppc_periph_model

// ==== tb.sv ====
// Self-checking bench for the peripheral port cycle controller
`timescale 1ns/1ps
module tb;
    reg clk, rst_n, hostValid, hostWrite, hostWord, regWrite, cfg128Strap;
    reg [6:0] hostAddr;
    reg [15:0] hostWdata, val;
    reg [7:0] regIndex, regWdata, tmg;
    reg [3:0] lat;
    wire hostReady, hostTrdy_n, hostError, peripheralSelect_n, peripheralReadyIn;
    wire peripheralReadStrobe_n, peripheralWriteStrobe_n, peripheralDataBusOe_n;
    wire [15:0] hostRdata, peripheralDataBusOut, peripheralDataBusIn, wrSeen;
    wire [7:0] regRdata;
    wire [6:0] peripheralAddressOut;
    integer fails, comparisons, i, n, pushed, done, base;
    ppc_cycle_ctrl ppc_cycle_ctrl_i (.clk, .rst_n, .hostValid, .hostReady, .hostWrite,
        .hostWord, .hostAddr, .hostWdata, .hostTrdy_n, .hostError, .hostRdata, .regWrite,
        .regIndex, .regWdata, .regRdata, .cfg128Strap, .peripheralAddressOut,
        .peripheralSelect_n, .peripheralReadStrobe_n, .peripheralWriteStrobe_n,
        .peripheralReadyIn, .peripheralDataBusIn, .peripheralDataBusOut, .peripheralDataBusOe_n);
    ppc_periph_model ppc_periph_model_i (.clk, .ackMode(tmg[1]), .lat, .val,
        .peripheralAddressOut, .peripheralReadStrobe_n, .peripheralWriteStrobe_n,
        .peripheralDataBusOut, .peripheralReadyIn, .peripheralDataBusIn, .wrSeen);
    initial
    begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
        if (hostTrdy_n === 1'b0)
            done <= done + 1;
    task wrap_up;
        begin
            if (fails == 0 && comparisons > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp)
            begin
                fails = fails + 1;
                $display("BAD %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wrReg(input [7:0] d);
        begin
            @(posedge clk);
            regWrite <= 1;
            regIndex <= 8'h19;
            regWdata <= d;
            @(posedge clk) regWrite <= 0;
        end
    endtask
    task rdReg(input [7:0] idx, input [7:0] e);
        begin
            @(posedge clk) regIndex <= idx;
            @(posedge clk);
            @(negedge clk) chk(regRdata, e);
        end
    endtask
    // Expected address pins for a byte lane in the strapped configuration
    function [7:0] pin(input [6:0] a, input [1:0] ln);
        pin = cfg128Strap ? {1'b0, a[6:2], 2'b00} : {3'h0, a[3:2], ln};
    endfunction
    task op(input [2:0] k, input [6:0] a, input [15:0] wd);
        reg [7:0] p0, p1;
        reg bad;
        begin
            @(posedge clk);
            p0 = pin(a, {a[1], k[1] ? 1'b0 : a[0]});
            p1 = pin(a, {a[1], 1'b1});
            bad = tmg[0] & !k[1];
            hostValid <= 1;
            hostWrite <= k[0];
            hostWord <= k[1];
            hostAddr <= a;
            hostWdata <= wd;
            do @(negedge clk); while (hostReady !== 1'b1);
            @(posedge clk) hostValid <= 0;
            for (n = 0; n < 300 && hostTrdy_n !== 1'b0; n = n + 1)
                @(negedge clk);
            chk(n < 300, 1);
            chk(hostError, bad);
            if (!bad && k[0])
                chk(wrSeen, tmg[0] ? wd : {8'h00, k[1] ? wd[15:8] : wd[7:0]});
            else if (!bad)
                chk(hostRdata, tmg[0] ? {val[15:8], val[7:0] ^ p0} :
                    {k[1] ? val[7:0] ^ p1 : 8'h00, val[7:0] ^ p0});
            repeat (3) @(posedge clk);
        end
    endtask
    initial
    begin
        {rst_n, hostValid, hostWrite, hostWord, regWrite, cfg128Strap} = 6'h00;
        {hostAddr, hostWdata, val, regIndex, regWdata, tmg, lat} = 0;
        fails = 0;
        comparisons = 0;
        done = 0;
        n = $urandom(32'h3a222abb);
        repeat (6) @(posedge clk);
        rst_n <= 1;
        rdReg(8'h19, 8'h00);
        wrReg(8'hff);
        rdReg(8'h19, 8'h3f);
        rdReg(8'h18, 8'h00);
        for (i = 0; i < 80; i = i + 1)
        begin
            // First pass is the minimum-timing byte write of 55h
            tmg = i ? $urandom & 8'h3f : 8'h00;
            wrReg(tmg);
            lat <= i ? $urandom % 9 : 0;
            val <= $urandom;
            cfg128Strap <= $urandom;
            op(i ? $urandom : 3'h1, i ? $urandom : 7'h00, i ? $urandom : 16'h0055);
        end
        tmg = 8'h00;
        wrReg(8'h00);
        lat <= 4'hf;
        base = done;
        @(posedge clk) hostValid <= 1;
        @(negedge clk);
        for (pushed = 0; hostReady === 1'b1 && pushed < 99; pushed = pushed + 1)
            @(negedge clk);
        @(posedge clk) hostValid <= 0;
        chk(pushed > 32, 1);
        rdReg(8'h19, 8'h80);
        for (n = 0; n < 3000 && done - base != pushed; n = n + 1)
            @(negedge clk);
        chk(done - base, pushed);
        wrap_up;
    end
    initial
    begin
        #300000;
        fails = fails + 1;
        wrap_up;
    end
endmodule // tb
bind ppc_cycle_ctrl ppc_cycle_props ppc_cycle_props_i (.clk, .rst_n, .hostTrdy_n, .hostError,
    .regWrite, .regIndex, .regWdata, .peripheralSelect_n, .peripheralReadStrobe_n,
    .peripheralWriteStrobe_n, .peripheralDataBusOut, .peripheralDataBusOe_n);
